//--- tcc_commutator.sv
// Telemetry commutator with sub-commutation and calibration generator
`timescale 1ns/1ps
`default_nettype none
module tcc_commutator #(
    parameter int W   = 12,
    parameter int DIV = 2777
) (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    input  wire logic [27*W-1:0]       data_i,
    input  wire logic [26:0]           subcom_en_i,
    input  wire logic [27*10*W-1:0]    sub_data_i,
    input  wire logic                  cal_cmd_i,
    output var  logic [W-1:0]          sample_o,
    output var  logic                  sample_vld_o,
    output var  logic [4:0]            slot_o,
    output var  logic [3:0]            sub_o,
    output var  logic                  sub_vld_o,
    output var  logic                  mframe_start_o,
    output var  logic                  cal_active_o,
    output var  logic [2:0]            cal_level_o
);
    typedef struct packed {
        logic [11:0]          div;
        logic [4:0]           slot;
        logic [3:0]           frame;
        tcc_pkg::tcc_mode_type mode;
        logic [2:0]           lvl;
        logic                 pend;
        logic [W-1:0]         sample;
        logic                 vld;
        logic [4:0]           slot_out;
        logic [3:0]           sub_out;
        logic                 sub_vld;
        logic                 mstart;
        logic                 cal;
        logic [2:0]           cal_lvl;
    } tcc_state_type;

    tcc_state_type st_q;
    tcc_state_type st_d;
    logic [W-1:0]  cal_val;
    logic          tick;
    logic          last_slot;
    logic          mf_wrap;
    logic [4:0]    didx;
    logic [W-1:0]  live;

    // Current registered level index feeds the ROM; its one clock of latency fits inside the DIV-clock sample period
    tcc_cal_rom #(.W(W)) u_rom (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .idx_i   (st_q.lvl),
        .level_o (cal_val)
    );

    assign tick      = (st_q.div == 12'(DIV - 1));
    assign last_slot = (st_q.slot == 5'(tcc_pkg::PRIM_CH - 1));
    assign mf_wrap   = tick && last_slot && (st_q.frame == 4'(tcc_pkg::SUB_CH - 1));
    // Slots 0..26 are data, 27..29 are references
    assign didx      = st_q.slot;

    always_comb begin
        live = '0;
        if (didx < 5'(tcc_pkg::DATA_CH)) begin
            if (subcom_en_i[didx]) begin
                live = sub_data_i[(didx*10 + st_q.frame)*W +: W];
            end else begin
                live = data_i[didx*W +: W];
            end
        end
    end

    always_comb begin
        st_d        = st_q;
        st_d.vld    = 1'b0;
        st_d.mstart = 1'b0;
        if (cal_cmd_i) begin
            st_d.pend = 1'b1;
        end
        if (tick) begin
            st_d.div = '0;
        end else begin
            st_d.div = st_q.div + 12'h001;
        end
        if (tick) begin
            // Sample output for the current slot
            st_d.vld      = 1'b1;
            st_d.slot_out = st_q.slot;
            st_d.sub_out  = st_q.frame;
            // Cal flags travel with the sample so they never change mid word
            st_d.cal      = (st_q.mode == tcc_pkg::TCC_CAL);
            st_d.cal_lvl  = st_q.lvl;
            st_d.mstart   = (st_q.slot == tcc_pkg::SLOT_RESET)
                            && (st_q.frame == tcc_pkg::SUB_RESET);
            if (didx == 5'd27) begin
                st_d.sample  = W'(tcc_pkg::REF_LO);
                st_d.sub_vld = 1'b0;
            end else if (didx == 5'd28) begin
                st_d.sample  = W'(tcc_pkg::REF_MID);
                st_d.sub_vld = 1'b0;
            end else if (didx == 5'd29) begin
                st_d.sample  = W'(tcc_pkg::REF_HI);
                st_d.sub_vld = 1'b0;
            end else begin
                st_d.sub_vld = subcom_en_i[didx];
                if (st_q.mode == tcc_pkg::TCC_CAL) begin
                    st_d.sample = cal_val;
                end else begin
                    st_d.sample = live;
                end
            end
            // Advance slot, then primary frame, fixed order
            if (last_slot) begin
                st_d.slot = '0;
                if (st_q.frame == 4'(tcc_pkg::SUB_CH - 1)) begin
                    st_d.frame = '0;
                end else begin
                    st_d.frame = st_q.frame + 4'h1;
                end
            end else begin
                st_d.slot = st_q.slot + 5'h01;
            end
        end
        // Calibration arms on any clock, but starts and steps levels only at master-frame boundaries
        unique case (st_q.mode)
            tcc_pkg::TCC_RUN: begin
                if (st_q.pend || cal_cmd_i) begin
                    st_d.mode = tcc_pkg::TCC_ARMED;
                end
            end
            tcc_pkg::TCC_ARMED: begin
                if (mf_wrap) begin
                    st_d.mode = tcc_pkg::TCC_CAL;
                    st_d.lvl  = '0;
                    st_d.pend = cal_cmd_i;
                end
            end
            tcc_pkg::TCC_CAL: begin
                if (mf_wrap) begin
                    if (st_q.lvl == 3'(tcc_pkg::CAL_LEVELS - 1)) begin
                        st_d.mode = tcc_pkg::TCC_RUN;
                        st_d.lvl  = '0;
                    end else begin
                        st_d.lvl = st_q.lvl + 3'h1;
                    end
                end
            end
            default: st_d.mode = tcc_pkg::TCC_RUN;
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sample_o       = st_q.sample;
    assign sample_vld_o   = st_q.vld;
    assign slot_o         = st_q.slot_out;
    assign sub_o          = st_q.sub_out;
    assign sub_vld_o      = st_q.sub_vld;
    assign mframe_start_o = st_q.mstart;
    assign cal_active_o   = st_q.cal;
    assign cal_level_o    = st_q.cal_lvl;
endmodule : tcc_commutator
`default_nettype wire

//--- tcc_pkg.sv
// Package: shared constants and types for the telemetry commutator
package tcc_pkg;
    localparam int unsigned CLK_HZ         = 10000000;
    localparam int unsigned PRIM_CH        = 30;
    localparam int unsigned DATA_CH        = 27;
    localparam int unsigned SUB_CH         = 10;
    localparam int unsigned PRIM_RATE_HZ   = 120;
    localparam int unsigned CAL_LEVELS     = 5;
    localparam int unsigned SAMPLE_DIV     = CLK_HZ / (PRIM_RATE_HZ * PRIM_CH);
    localparam int unsigned SMP_W          = 12;
    localparam logic [4:0]  SLOT_RESET     = 5'h00;
    localparam logic [3:0]  SUB_RESET      = 4'h0;
    localparam logic [SMP_W-1:0] REF_LO    = 12'h000;
    localparam logic [SMP_W-1:0] REF_MID   = 12'h800;
    localparam logic [SMP_W-1:0] REF_HI    = 12'hfff;
    typedef enum logic [1:0] {TCC_RUN, TCC_ARMED, TCC_CAL} tcc_mode_type;
endpackage : tcc_pkg

//--- tcc_cal_rom.sv
// Calibration level table with registered read data
`timescale 1ns/1ps
`default_nettype none
module tcc_cal_rom #(
    parameter int W = 12
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    input  wire logic [2:0]   idx_i,
    output var  logic [W-1:0] level_o
);
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;

    always_comb begin
        unique case (idx_i)
            3'h0:    level_d = W'(12'h000);
            3'h1:    level_d = W'(12'h400);
            3'h2:    level_d = W'(12'h800);
            3'h3:    level_d = W'(12'hc00);
            3'h4:    level_d = W'(12'hfff);
            default: level_d = W'(12'h000);
        endcase
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            level_q <= '0;
        end else begin
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule : tcc_cal_rom
`default_nettype wire

//--- tcc_commutator_note_end.sv
// Spare file, holds no logic

//--- tcc_pcm_sink.sv
// Encoder-side model that captures each time-shared sample word
`timescale 1ns/1ps
`default_nettype none
module tcc_pcm_sink (
    input  wire logic        mclk_i,
    input  wire logic        vld_i,
    input  wire logic [23:0] word_i,
    output var  logic        got_o,
    output var  logic [23:0] word_o
);
    // Takes data only on the strobe, like a real encoder
    always_ff @(posedge mclk_i) begin
        got_o <= vld_i;
        if (vld_i) begin
            word_o <= word_i;
        end
    end
endmodule : tcc_pcm_sink
`default_nettype wire

//--- tcc_commutator_assertions.sv
// Port-level checker for the commutator
`timescale 1ns/1ps
`default_nettype none
module tcc_commutator_chk #(
    parameter int W   = 12,
    parameter int DIV = 2777
) (
    input wire logic         mclk_i,
    input wire logic         rst_i,
    input wire logic [W-1:0] sample_o,
    input wire logic         sample_vld_o,
    input wire logic [4:0]   slot_o,
    input wire logic [3:0]   sub_o,
    input wire logic         sub_vld_o,
    input wire logic         mframe_start_o,
    input wire logic         cal_active_o,
    input wire logic [2:0]   cal_level_o
);
    logic        seen_q;
    logic [4:0]  slot_q;
    logic [3:0]  sub_q;
    int          gap_q;
    logic [11:0] lv [5] = '{12'h000, 12'h400, 12'h800, 12'hc00, 12'hfff};
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            seen_q <= 1'b0;
            gap_q <= 0;
        end else begin
            gap_q <= sample_vld_o ? 0 : gap_q + 1;
            if (sample_vld_o) begin
                seen_q <= 1'b1;
                slot_q <= slot_o;
                sub_q <= sub_o;
            end
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    a_index_range: assert property (sample_vld_o |-> slot_o < 5'h1e && sub_o < 4'ha)
        else $error("index out of range");
    a_tick_gap: assert property (sample_vld_o && seen_q |-> gap_q == DIV - 1)
        else $error("sample spacing wrong");
    a_slot_order: assert property (sample_vld_o && seen_q |->
        slot_o == (slot_q == 5'h1d ? 5'h00 : slot_q + 5'h01))
        else $error("slot order broken");
    a_frame_order: assert property (sample_vld_o && seen_q |-> sub_o == (slot_o != 5'h00 ? sub_q
        : sub_q == 4'h9 ? 4'h0 : sub_q + 4'h1))
        else $error("frame order broken");
    a_mframe_mark: assert property (mframe_start_o == (sample_vld_o && slot_o == 5'h00
        && sub_o == 4'h0))
        else $error("master frame mark wrong");
    a_ref_slots: assert property (sample_vld_o && slot_o > 5'h1a |-> !sub_vld_o && sample_o
        == (slot_o == 5'h1b ? 12'h000 : slot_o == 5'h1c ? 12'h800 : 12'hfff))
        else $error("reference slot wrong");
    a_cal_value: assert property (sample_vld_o && cal_active_o && slot_o < 5'h1b |->
        sample_o == lv[cal_level_o])
        else $error("calibration level wrong");
    a_cal_steady: assert property (sample_vld_o && !mframe_start_o |-> $stable(cal_active_o)
        && $stable(cal_level_o))
        else $error("calibration changed mid frame");
endmodule : tcc_commutator_chk
bind tcc_commutator tcc_commutator_chk #(.W(W), .DIV(DIV)) i_tcc_commutator_chk (.mclk_i,
    .rst_i, .sample_o, .sample_vld_o, .slot_o, .sub_o, .sub_vld_o, .mframe_start_o,
    .cal_active_o, .cal_level_o);
`default_nettype wire

//--- tcc_commutator_tb.sv
// Self-checking bench for the commutator
`timescale 1ns/1ps
`default_nettype none
module tcc_commutator_tb;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [323:0] data_i = '0;
    logic [26:0] subcom_en_i = '0;
    logic [3239:0] sub_data_i = '0;
    logic cal_cmd_i = 1'b0;
    logic [11:0] sample_o, v;
    logic sample_vld_o, sub_vld_o, mframe_start_o, cal_active_o, got, cal;
    logic [4:0] slot_o;
    logic [3:0] sub_o;
    logic [2:0] cal_level_o;
    logic [23:0] word;
    logic [23:0] exp_q [$];
    logic [2:0] lvl_q [$];
    logic [11:0] lv [5] = '{12'h000, 12'h400, 12'h800, 12'hc00, 12'hfff};
    int fails = 0;
    int total_checks = 0;
    int n, s, f, m, k;
    always #50 mclk_i = ~mclk_i;
    tcc_commutator #(.W(12), .DIV(4)) i_tcc_commutator (.mclk_i, .rst_i, .data_i, .subcom_en_i,
        .sub_data_i, .cal_cmd_i, .sample_o, .sample_vld_o, .slot_o, .sub_o, .sub_vld_o,
        .mframe_start_o, .cal_active_o, .cal_level_o);
    tcc_pcm_sink i_tcc_pcm_sink (.mclk_i, .vld_i(sample_vld_o), .got_o(got), .word_o(word),
        .word_i({slot_o, sub_o, sub_vld_o, mframe_start_o, cal_active_o, sample_o}));
    task automatic check(input string what, input logic [23:0] e, input logic [23:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done
    // Sink flops update on the rising edge, so look on the falling one
    always @(negedge mclk_i) begin
        if (got && exp_q.size() > 0) check("sample", exp_q.pop_front(), word);
        if (got && lvl_q.size() > 0) check("level", {21'h0, lvl_q.pop_front()}, {21'h0, cal_level_o});
    end
    initial begin
        void'($urandom(32'hcc41));
        for (n = 0; n < 3240; n++) begin
            sub_data_i[n] = 1'($urandom);
            if (n < 324) data_i[n] = 1'($urandom);
        end
        // Mixed selection, one channel forced each way
        subcom_en_i = (27'($urandom) | 27'h1) & ~27'h2;
        for (n = 0; n < 2400; n++) begin
            s = n % 30;
            f = (n / 30) % 10;
            m = n / 300;
            cal = m > 1 && m < 7;
            v = s > 26 ? (s == 27 ? 12'h000 : s == 28 ? 12'h800 : 12'hfff) : cal ? lv[m - 2]
                : subcom_en_i[s] ? sub_data_i[(s * 10 + f) * 12 +: 12] : data_i[s * 12 +: 12];
            exp_q.push_back({5'(s), 4'(f), s < 27 && subcom_en_i[s], s == 0 && f == 0, cal, v});
            lvl_q.push_back(cal ? 3'(m - 2) : 3'h0);
        end
        repeat (2) @(posedge mclk_i);
        #10 rst_i = 1'b0;
        n = 0;
        // Command lands mid master frame, so cal must wait for the next one
        for (k = 0; k < 3000 && n < 2; k++) begin
            @(posedge mclk_i);
            if (mframe_start_o === 1'b1) n++;
        end
        #10 cal_cmd_i = 1'b1;
        @(posedge mclk_i);
        #10 cal_cmd_i = 1'b0;
        for (k = 0; k < 12000 && exp_q.size() > 0; k++) @(posedge mclk_i);
        if (n < 2 || exp_q.size() > 0) fails++;
        test_done();
    end
endmodule : tcc_commutator_tb
`default_nettype wire
